/* rtl/sfc_pkg.sv */
/*
 * Package for the serial frame and fail-safe control block: sizes, register
 * indices, field positions, reset values, synchroniser lanes, state codes
 * and the timing counts of the fail-safe waveforms.
 * Assumes a 40 MHz system clock; the waveform counts derive from it.
 */
package sfc_pkg;

	// ==========================================================
	// Frame geometry
	localparam int FRAME_BITS = 16;
	localparam int HDR_BITS = 4;
	localparam int DATA_W = 12;
	localparam int ADDR_W = 3;
	localparam int CNT_W = 5;
	localparam int NUM_REGS = 8;
	localparam logic [3:0] DATA_TOP_BIT = 4'hb;

	// ==========================================================
	// Register indices
	localparam logic [2:0] REG_MODE_WD = 3'h0;
	localparam logic [2:0] REG_CTRL1 = 3'h1;
	localparam logic [2:0] REG_CTRL2 = 3'h2;
	localparam logic [2:0] REG_INTEN = 3'h3;
	localparam logic [2:0] REG_EVENTS = 3'h4;
	localparam logic [2:0] REG_CAUSE = 3'h5;
	localparam logic [2:0] REG_STATUS = 3'h6;
	localparam logic [2:0] REG_GP = 3'h7;

	// ==========================================================
	// Field positions
	localparam int BIT_FS_SW = 6;
	localparam int BIT_TWAR_EVT = 4;
	localparam int BIT_SPI_FAIL = 0;
	localparam int CAUSE_LSB = 3;
	localparam int CAUSE_W = 4;
	localparam int CAUSE_THERMAL = 0;
	localparam int CAUSE_WD = 1;
	localparam int CAUSE_CLAMP = 2;
	localparam int CAUSE_FATAL = 3;
	localparam int STAT_SWDEV = 5;
	localparam int STAT_CFG = 4;
	localparam int STAT_TWAR = 2;

	// Reset value of the general purpose register; value is arbitrary
	localparam logic [11:0] GP_RESET_ID = 12'h5a3;

	// ==========================================================
	// Synchroniser lanes
	localparam int SYNC_W = 6;
	localparam int SY_WARN = 0;
	localparam int SY_SD = 1;
	localparam int SY_SWDEV = 2;
	localparam int SY_CFG = 3;
	localparam int SY_CSN = 4;
	localparam int SY_SCK = 5;

	// ==========================================================
	// Timing of the fail-safe waveforms
	localparam int CLK_PERIOD_NS = 25;
	localparam int SLOW_HALF_NS = 400_000_000;
	localparam int FAST_PERIOD_NS = 10_000_000;
	localparam int FAST_LOW_NS = 2_000_000;
	localparam int WAVE_CNT_W = 24;
	localparam int SLOW_HALF_CYC = SLOW_HALF_NS / CLK_PERIOD_NS;
	localparam int FAST_PERIOD_CYC = FAST_PERIOD_NS / CLK_PERIOD_NS;
	localparam int FAST_LOW_CYC = FAST_LOW_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		CFG_POLICY_RESET = 2'b00,
		CFG_POLICY_FS = 2'b01,
		CFG_SW_DEV = 2'b10
	} sfc_cfg_type;

	typedef enum logic [1:0] {
		SPI_IDLE = 2'b00,
		SPI_ACTIVE = 2'b01,
		SPI_COMMIT = 2'b10
	} sfc_spi_state_type;

endpackage

/* rtl/sfc_fs_if.sv */
/*
 * Interface between the frame controller and the fail-safe waveform
 * generator: the common activation level and the two waveform phases.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface sfc_fs_if;
	logic active; // Internal fail-safe level
	logic slow_low; // Slow wave in its driving-low phase
	logic fast_low; // Fast wave in its driving-low phase

	modport gen (input active, output slow_low, output fast_low);
	modport ctl (output active, input slow_low, input fast_low);
endinterface

`default_nettype wire

/* rtl/sfc_fs_wave.sv */
/*
 * Fail-safe waveform generator: a 50 percent slow wave and a 20 percent
 * fast wave, both starting in the low phase when activation rises.
 * Assumes the activation level is synchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module sfc_fs_wave
	import sfc_pkg::*;
#(
	parameter logic [WAVE_CNT_W-1:0] SLOW_HALF = WAVE_CNT_W'(SLOW_HALF_CYC),
	parameter logic [WAVE_CNT_W-1:0] FAST_PERIOD = WAVE_CNT_W'(FAST_PERIOD_CYC),
	parameter logic [WAVE_CNT_W-1:0] FAST_LOW = WAVE_CNT_W'(FAST_LOW_CYC)
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	sfc_fs_if.gen fs
);

	logic run; // Waveforms running
	logic [WAVE_CNT_W-1:0] slow_cnt; // Cycles in current slow phase
	logic [WAVE_CNT_W-1:0] fast_cnt; // Cycles in current fast period
	logic [WAVE_CNT_W-1:0] next_fast_cnt;

	// ==========================================================
	// Run flag follows activation
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run <= 1'b0;
		end else begin
			run <= fs.active;
		end
	end

	// Slow wave: toggle every half period, low phase first
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			slow_cnt <= '0;
			fs.slow_low <= 1'b0;
		end else if (!fs.active) begin
			slow_cnt <= '0;
			fs.slow_low <= 1'b0;
		end else if (!run) begin
			slow_cnt <= '0;
			fs.slow_low <= 1'b1;
		end else if (slow_cnt == SLOW_HALF - 1'b1) begin
			slow_cnt <= '0;
			fs.slow_low <= !fs.slow_low;
		end else begin
			slow_cnt <= slow_cnt + 1'b1;
		end
	end

	// Next fast count wraps at the period
	always_comb begin
		if (!run || fast_cnt == FAST_PERIOD - 1'b1) begin
			next_fast_cnt = '0;
		end else begin
			next_fast_cnt = fast_cnt + 1'b1;
		end
	end

	// Fast wave: low for the first fifth of each period
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fast_cnt <= '0;
			fs.fast_low <= 1'b0;
		end else if (!fs.active) begin
			fast_cnt <= '0;
			fs.fast_low <= 1'b0;
		end else begin
			fast_cnt <= next_fast_cnt;
			fs.fast_low <= (next_fast_cnt < FAST_LOW);
		end
	end

	// ==========================================================
	// Checks
	a_slow_first_low: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(fs.active) |=> fs.slow_low && fs.fast_low)
		else $error("fail-safe waves did not start low");

endmodule // sfc_fs_wave

`default_nettype wire

/* rtl/sfc_top.sv */
/*
 * Serial frame handler and fail-safe control: 16-bit slave frames on
 * their own clock, eight 12-bit registers, thermal events, fail-safe
 * activation, configuration pin latching and three open-drain outputs.
 * Assumes the master keeps its clock low at select edges, leaves at
 * least 100 ns from select fall to first clock edge and 150 ns between
 * frames, and that mode and failure inputs are synchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Warning comparator change sets thermal event
// - Shutdown enters fail-safe, leaves after cooling
// - Static output low while fail-safe active
// - Slow output blinks 1.25 Hz, 50 percent
// - Fast output pulses 100 Hz, 20 percent
// - Fail-safe asserts on failure or software bit
// - Development setup ignores watchdog and clamp failures
// - Software bit cleared deactivates software fail-safe
// - Clearing cause flags deactivates failure fail-safe
// - Start-up with fail-safe blocks most writes
// - Clamped reset activates; mode only policy fail-safe
// - Pins latched only during configuration mode
// - Development pin wins, else policy pin decides
// - Select high ignores link, output released
// - Sample falling, shift rising, MSB first
// - Ready bit shown; not ready ignores frame
// - Header bits echoed from input to output
// - Three address bits pick one register
// - Access bit high means read-only
// - Write data committed at select rising edge
// - Output data is register content at start
// - Clock low at edges, 0 or 16 clocks
module sfc_top
	import sfc_pkg::*;
#(
	parameter int unsigned SLOW_HALF_CYCLES = SLOW_HALF_CYC,
	parameter int unsigned FAST_PERIOD_CYCLES = FAST_PERIOD_CYC,
	parameter int unsigned FAST_LOW_CYCLES = FAST_LOW_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_spi_clk,
	input wire logic i_spi_cs_n,
	input wire logic i_spi_di,
	output logic o_sdo,
	output logic o_sdo_oe,
	input wire logic i_warn_above,
	input wire logic i_shutdown_above,
	input wire logic i_sw_development_pin,
	input wire logic i_cfg_pin,
	input wire logic i_config_mode,
	input wire logic i_startup_mode,
	input wire logic i_wd_fail,
	input wire logic i_reset_clamped_low,
	input wire logic i_fatal_failure,
	input wire logic i_failsafe_leave,
	output logic o_failsafe_static_out,
	output logic o_failsafe_static_oe,
	output logic o_failsafe_slow_blink_out,
	output logic o_failsafe_slow_blink_oe,
	output logic o_failsafe_fast_pulse_out,
	output logic o_failsafe_fast_pulse_oe,
	output logic o_failsafe_active_internal,
	output logic o_failsafe_mode,
	output logic o_wakeup_disable,
	output logic o_reset_pulse_req,
	output logic o_thermal_warning_event,
	output logic o_spi_fail_event,
	output logic o_config_sw_dev
);

	// ==========================================================
	// Decode functions
	function automatic logic is_read_clear(input logic [2:0] a);
		return (a == REG_EVENTS) || (a == REG_CAUSE);
	endfunction

	function automatic logic is_writable(input logic [2:0] a);
		return !is_read_clear(a) && (a != REG_STATUS);
	endfunction

	// ==========================================================
	// Declarations
	logic [SYNC_W-1:0] sync1; // First stage, read only by sync2
	logic [SYNC_W-1:0] sync2; // Synchronised pins
	logic warn_q; // Previous warning level
	logic sd_q; // Previous shutdown level
	sfc_cfg_type cfg; // Latched configuration
	sfc_spi_state_type state; // Frame state
	logic ready_frame; // Ready flag latched at frame start
	logic refuse_next; // Select fell while busy
	logic sck_bad; // Clock high at a select edge
	logic [CNT_W-1:0] cnt_prev; // Fall count at end of last frame
	logic [CNT_W-1:0] cnt_end; // Fall count at end of this frame
	logic [FRAME_BITS-1:0] rx_cap; // Received frame
	logic [DATA_W-1:0] regs [NUM_REGS]; // Register file
	logic [DATA_W-1:0] next_regs [NUM_REGS];
	logic [DATA_W-1:0] snap [NUM_REGS]; // Frame start copy
	logic fs_fail; // Fail-safe caused by failure
	logic thermal_lock; // Fail-safe held by temperature
	logic od_zero; // Open-drain data level
	// Link side
	logic [CNT_W-1:0] fcnt; // Falling edges while selected
	logic [FRAME_BITS-1:0] rx; // Input shift register
	logic [CNT_W-1:0] rcnt; // Rising edges in this frame
	logic [2:0] hdr_addr; // Address held after header
	logic rdy_s1; // First stage, read only by rdy_s2
	logic rdy_s2; // Ready level in link domain
	logic frame_rst; // Link frame reset
	// Combinational
	logic warn_s, sd_s, csn_s, sck_s;
	logic twar_evt, sd_rise, wd_q, clamp_q;
	logic [CAUSE_W-1:0] cause_evt;
	logic fs_active, cool;
	logic [CNT_W-1:0] nclk;
	logic frame_ok, data_frame, blocked, wr_accept, rc_accept, spi_fail_evt;
	logic [2:0] f_addr;
	logic [DATA_W-1:0] status_word;
	logic [2:0] sel_addr;
	logic [3:0] out_idx;

	sfc_fs_if fs_bus ();

	assign warn_s = sync2[SY_WARN];
	assign sd_s = sync2[SY_SD];
	assign csn_s = sync2[SY_CSN];
	assign sck_s = sync2[SY_SCK];

	// ==========================================================
	// Pin synchronisers and edge history
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1 <= 6'h10;
			sync2 <= 6'h10;
			warn_q <= 1'b0;
			sd_q <= 1'b0;
		end else begin
			sync1 <= {i_spi_clk, i_spi_cs_n, i_cfg_pin,
				i_sw_development_pin, i_shutdown_above, i_warn_above};
			sync2 <= sync1;
			warn_q <= warn_s;
			sd_q <= sd_s;
		end
	end

	// Pins latched only in configuration mode
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg <= CFG_POLICY_RESET;
		end else if (i_config_mode) begin
			if (sync2[SY_SWDEV]) begin
				cfg <= CFG_SW_DEV;
			end else if (sync2[SY_CFG]) begin
				cfg <= CFG_POLICY_FS;
			end else begin
				cfg <= CFG_POLICY_RESET;
			end
		end
	end

	// ==========================================================
	// Events and failure qualification
	always_comb begin
		twar_evt = warn_s ^ warn_q;
		sd_rise = sd_s && !sd_q;
		wd_q = i_wd_fail && (cfg != CFG_SW_DEV);
		clamp_q = i_reset_clamped_low && (cfg != CFG_SW_DEV);
		cause_evt = '0;
		cause_evt[CAUSE_THERMAL] = sd_rise;
		cause_evt[CAUSE_WD] = wd_q;
		cause_evt[CAUSE_CLAMP] = clamp_q;
		cause_evt[CAUSE_FATAL] = i_fatal_failure;
		fs_active = fs_fail || regs[REG_CTRL2][BIT_FS_SW];
		cool = !warn_s && !sd_s;
	end

	// ==========================================================
	// Frame decode at commit
	always_comb begin
		f_addr = rx_cap[FRAME_BITS-1 -: ADDR_W];
		nclk = cnt_end - cnt_prev;
		frame_ok = !sck_bad && (nclk == 5'h00 || nclk == 5'h10);
		data_frame = (state == SPI_COMMIT) && frame_ok && ready_frame
			&& (nclk == 5'h10);
		blocked = i_startup_mode && fs_active && (f_addr != REG_MODE_WD);
		wr_accept = data_frame && !rx_cap[DATA_W] && !blocked
			&& is_writable(f_addr);
		rc_accept = data_frame && !rx_cap[DATA_W] && !blocked
			&& is_read_clear(f_addr);
		spi_fail_evt = (state == SPI_COMMIT) && !frame_ok;
		status_word = '0;
		status_word[STAT_SWDEV] = (cfg == CFG_SW_DEV);
		status_word[STAT_CFG] = (cfg == CFG_POLICY_FS);
		status_word[STAT_TWAR] = warn_s;
	end

	// Frame state: wait, collect, commit
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= SPI_IDLE;
			ready_frame <= 1'b1;
			refuse_next <= 1'b0;
			sck_bad <= 1'b0;
			cnt_prev <= '0;
			cnt_end <= '0;
			rx_cap <= '0;
		end else begin
			unique case (state)
				SPI_IDLE: begin
					if (!csn_s) begin
						state <= SPI_ACTIVE;
						ready_frame <= !refuse_next;
						refuse_next <= 1'b0;
						sck_bad <= sck_s;
					end
				end
				SPI_ACTIVE: begin
					if (csn_s) begin
						state <= SPI_COMMIT;
						sck_bad <= sck_bad || sck_s;
						cnt_end <= fcnt;
						rx_cap <= rx;
					end
				end
				SPI_COMMIT: begin
					state <= SPI_IDLE;
					cnt_prev <= cnt_end;
					refuse_next <= !csn_s;
				end
				default: begin
					state <= SPI_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Register file: clear first, then events set, so set wins
	always_comb begin
		next_regs = regs;
		if (wr_accept) begin
			next_regs[f_addr] = rx_cap[DATA_W-1:0];
		end
		if (rc_accept) begin
			next_regs[f_addr] = '0;
		end
		next_regs[REG_STATUS] = status_word;
		next_regs[REG_EVENTS][BIT_TWAR_EVT] =
			next_regs[REG_EVENTS][BIT_TWAR_EVT] || twar_evt;
		next_regs[REG_EVENTS][BIT_SPI_FAIL] =
			next_regs[REG_EVENTS][BIT_SPI_FAIL] || spi_fail_evt;
		for (int k = 0; k < CAUSE_W; k++) begin
			next_regs[REG_CAUSE][CAUSE_LSB+k] =
				next_regs[REG_CAUSE][CAUSE_LSB+k] || cause_evt[k];
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs[i] <= (i == int'(REG_GP)) ? GP_RESET_ID : '0;
			end
		end else begin
			regs <= next_regs;
		end
	end

	// Copy frozen while a frame runs
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				snap[i] <= '0;
			end
		end else if (state == SPI_IDLE && csn_s) begin
			snap <= regs;
		end
	end

	// ==========================================================
	// Fail-safe activation and mode
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fs_fail <= 1'b0;
		end else if (|cause_evt) begin
			fs_fail <= 1'b1;
		end else if (rc_accept && f_addr == REG_CAUSE) begin
			fs_fail <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			thermal_lock <= 1'b0;
		end else if (sd_rise) begin
			thermal_lock <= 1'b1;
		end else if (cool) begin
			thermal_lock <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_failsafe_mode <= 1'b0;
		end else if (sd_rise || i_fatal_failure
			|| ((wd_q || clamp_q) && cfg == CFG_POLICY_FS)) begin
			o_failsafe_mode <= 1'b1;
		end else if (thermal_lock ? cool : i_failsafe_leave) begin
			o_failsafe_mode <= 1'b0;
		end
	end

	// ==========================================================
	// Output flops
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			od_zero <= 1'b0;
			o_failsafe_static_oe <= 1'b0;
			o_failsafe_slow_blink_oe <= 1'b0;
			o_failsafe_fast_pulse_oe <= 1'b0;
			o_failsafe_active_internal <= 1'b0;
			o_wakeup_disable <= 1'b0;
			o_reset_pulse_req <= 1'b0;
			o_sdo_oe <= 1'b0;
		end else begin
			od_zero <= 1'b0;
			o_failsafe_static_oe <= fs_active;
			o_failsafe_slow_blink_oe <= fs_active && fs_bus.slow_low;
			o_failsafe_fast_pulse_oe <= fs_active && fs_bus.fast_low;
			o_failsafe_active_internal <= fs_active;
			o_wakeup_disable <= thermal_lock || sd_rise;
			o_reset_pulse_req <= (wd_q || clamp_q)
				&& cfg == CFG_POLICY_RESET;
			o_sdo_oe <= !csn_s;
		end
	end

	assign o_failsafe_static_out = od_zero;
	assign o_failsafe_slow_blink_out = od_zero;
	assign o_failsafe_fast_pulse_out = od_zero;
	assign o_thermal_warning_event = regs[REG_EVENTS][BIT_TWAR_EVT];
	assign o_spi_fail_event = regs[REG_EVENTS][BIT_SPI_FAIL];
	assign o_config_sw_dev = cfg[1];
	assign fs_bus.active = fs_active;

	sfc_fs_wave #(
		.SLOW_HALF(WAVE_CNT_W'(SLOW_HALF_CYCLES)),
		.FAST_PERIOD(WAVE_CNT_W'(FAST_PERIOD_CYCLES)),
		.FAST_LOW(WAVE_CNT_W'(FAST_LOW_CYCLES))
	) u_wave (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.fs(fs_bus.gen)
	);

	// ==========================================================
	// Link domain: sample on falling edges while selected
	always_ff @(negedge i_spi_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			fcnt <= '0;
			rx <= '0;
		end else if (!i_spi_cs_n) begin
			rx <= {rx[FRAME_BITS-2:0], i_spi_di};
			fcnt <= fcnt + 1'b1;
		end
	end

	// Ready level into the link domain
	always_ff @(posedge i_spi_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdy_s1 <= 1'b1;
			rdy_s2 <= 1'b1;
		end else begin
			rdy_s1 <= ready_frame;
			rdy_s2 <= rdy_s1;
		end
	end

	assign frame_rst = i_spi_cs_n || !i_reset_n;

	always_comb begin
		sel_addr = (rcnt == 5'h04) ? rx[HDR_BITS-1:1] : hdr_addr;
		out_idx = DATA_TOP_BIT - (rcnt[3:0] - 4'h4);
	end

	// Shift out on rising edges; idle level high, not ready drives zeros
	always_ff @(posedge i_spi_clk or posedge frame_rst) begin
		if (frame_rst) begin
			rcnt <= '0;
			hdr_addr <= '0;
			o_sdo <= 1'b1;
		end else begin
			if (rcnt != 5'h1f) begin
				rcnt <= rcnt + 1'b1;
			end
			if (rcnt == 5'h04) begin
				hdr_addr <= rx[HDR_BITS-1:1];
			end
			if (!rdy_s2) begin
				o_sdo <= 1'b0;
			end else if (rcnt < 5'(HDR_BITS)) begin
				o_sdo <= i_spi_di;
			end else if (rcnt < 5'(FRAME_BITS)) begin
				o_sdo <= snap[sel_addr][out_idx];
			end else begin
				o_sdo <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Checks
	a_static_follows: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) fs_active |=> o_failsafe_static_oe)
		else $error("static output not driven while active");
	a_twar_sets: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) (warn_s != $past(warn_s)) |=> o_thermal_warning_event)
		else $error("thermal event missed");
	a_shutdown_enter: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) sd_rise |=> o_failsafe_mode && o_wakeup_disable)
		else $error("shutdown did not enter fail-safe");
	a_swdev_ignores: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) (cfg == CFG_SW_DEV && !fs_fail && !sd_rise
		&& !i_fatal_failure && !o_failsafe_mode) |=> !fs_fail && !o_failsafe_mode)
		else $error("development setup entered fail-safe");
	a_sw_release: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) ($fell(regs[REG_CTRL2][BIT_FS_SW]) && !fs_fail)
		|=> !o_failsafe_active_internal)
		else $error("software release ignored");
	a_cause_release: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) (rc_accept && f_addr == REG_CAUSE
		&& !(|cause_evt) && !regs[REG_CTRL2][BIT_FS_SW])
		|=> !fs_fail ##1 !o_failsafe_static_oe)
		else $error("cause clear did not release");
	a_startup_block: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) (i_startup_mode && fs_active && f_addr != REG_MODE_WD)
		|-> !wr_accept && !rc_accept)
		else $error("write taken during start-up fail-safe");
	a_clamp_policy: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) (i_reset_clamped_low && cfg == CFG_POLICY_FS)
		|=> o_failsafe_mode && fs_fail)
		else $error("clamped reset missed");
	a_pins_hold: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) !i_config_mode |=> $stable(cfg))
		else $error("configuration changed outside config mode");
	a_write_commit: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) (wr_accept && f_addr == REG_CTRL1)
		|=> regs[REG_CTRL1] == $past(rx_cap[DATA_W-1:0]))
		else $error("write data not committed");
	a_bad_frame: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) spi_fail_evt |=> o_spi_fail_event)
		else $error("frame failure not flagged");

endmodule // sfc_top

`default_nettype wire

/* sim/sfc_spi_master.sv */
/* Master model of the serial link: 16-bit frames, clock 32 ns.
   Assumes the slave samples on falling and shifts on rising edges. */
`timescale 1ns/1ps
`default_nettype none
module sfc_spi_master (
	output logic o_sck,
	output logic o_cs_n,
	output logic o_di,
	input wire logic i_sdo
);
	// ==========================================================
	// Idle link: clock low, select high
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_di = 1'b0;
	end
	// One frame of n clocks, MSB first, clock low at select edges
	task automatic xfer(input logic [15:0] tx, input int n,
		output logic [15:0] rx);
		rx = '0;
		o_cs_n = 1'b0;
		o_di = tx[15];
		#150;
		for (int i = 0; i < n; i++) begin
			o_sck = 1'b1;
			#16;
			o_sck = 1'b0;
			rx = {rx[14:0], i_sdo};
			// Next bit mid-low, away from both clock edges
			#8;
			o_di = tx[4'(14 - i)];
			#8;
		end
		#100;
		o_cs_n = 1'b1;
		// Released data line shows no stale value
		o_di = ~o_di;
		#50;
	endtask
endmodule // sfc_spi_master
`default_nettype wire

/* sim/sfc_top_bench.sv */
/* Self-checking bench of sfc_top against a register model.
   Assumes the master model of sfc_spi_master.sv. */
`timescale 1ns/1ps
`default_nettype none
module sfc_top_bench;
	import sfc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sck, cs_n, di, sdo, sdo_oe, warn, swdev, cfgp, cfgm, fatal, clamp;
	logic sd, sum, blk;
	logic act, mode, spif, swd, st_oe, sl_oe, fa_oe, wkd, rpr, twe;
	logic [2:0] fso_d;
	int err_total = 0;
	int tests_run = 0;
	int mdl [8];
	logic [15:0] n_sl;
	logic [15:0] n_fa;
	logic [15:0] rx;
	// ==========================================================
	// Clock, design and master
	always #12.5 clk = ~clk;
	sfc_top #(.SLOW_HALF_CYCLES(20), .FAST_PERIOD_CYCLES(10),
		.FAST_LOW_CYCLES(2)) i_dut (.i_clk(clk), .i_reset_n(rst_n),
		.i_spi_clk(sck), .i_spi_cs_n(cs_n), .i_spi_di(di), .o_sdo(sdo),
		.o_sdo_oe(sdo_oe), .i_warn_above(warn), .i_shutdown_above(sd),
		.i_sw_development_pin(swdev), .i_cfg_pin(cfgp),
		.i_config_mode(cfgm), .i_startup_mode(sum), .i_wd_fail(1'b0),
		.i_reset_clamped_low(clamp), .i_fatal_failure(fatal),
		.i_failsafe_leave(1'b0), .o_failsafe_static_out(fso_d[0]),
		.o_failsafe_static_oe(st_oe),
		.o_failsafe_slow_blink_out(fso_d[1]),
		.o_failsafe_slow_blink_oe(sl_oe),
		.o_failsafe_fast_pulse_out(fso_d[2]),
		.o_failsafe_fast_pulse_oe(fa_oe), .o_failsafe_active_internal(act),
		.o_failsafe_mode(mode), .o_wakeup_disable(wkd),
		.o_reset_pulse_req(rpr),
		.o_thermal_warning_event(twe), .o_spi_fail_event(spif),
		.o_config_sw_dev(swd));
	sfc_spi_master i_mst (.o_sck(sck), .o_cs_n(cs_n), .o_di(di),
		.i_sdo(sdo));
	// ==========================================================
	// Compare, access and verdict
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Frame with model update; refused frames leave the model alone
	task automatic acc(input logic [2:0] a, input logic ro,
		input logic [11:0] d);
		logic upd;
		i_mst.xfer({a, ro, d}, 16, rx);
		upd = !ro && !(blk && a != 3'h0);
		chk(rx, {a, ro, mdl[a][11:0]});
		if (upd && a inside {[0:3], 7}) mdl[a] = d;
		if (upd && a inside {4, 5}) mdl[a] = 0;
		repeat (8) @(negedge clk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#300us;
		err_total++;
		tally_and_finish();
	end
	// ==========================================================
	// Main sequence
	initial begin
		{warn, sd, sum, blk, swdev, fatal, clamp} = '0;
		cfgp = 1'b1;
		cfgm = 1'b1;
		void'($urandom(32'h47743f0a));
		foreach (mdl[i]) mdl[i] = 0;
		mdl[7] = 12'h5a3;
		mdl[6] = 1 << STAT_CFG;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		cfgm = 1'b0;
		repeat (4) @(negedge clk);
		swdev = 1'b1;
		chk({sdo_oe, sdo}, 2'b01);
		for (int a = 0; a < 8; a++) acc(a, 1'b0, 12'($urandom) & 12'hfbf);
		for (int a = 0; a < 8; a++) acc(a, 1'b1, 12'($urandom));
		chk(swd, 1'b0);
		acc(3'h2, 1'b0, 12'h040);
		chk({act, st_oe, sl_oe}, 3'h7);
		n_sl = 0;
		n_fa = 0;
		repeat (40) begin
			@(negedge clk);
			n_sl += sl_oe;
			n_fa += fa_oe;
		end
		chk(n_sl, 16'd20);
		chk(n_fa, 16'd8);
		acc(3'h2, 1'b0, 12'h000);
		chk(act, 1'b0);
		{fatal, clamp} = 2'b11;
		@(negedge clk) {fatal, clamp} = 2'b00;
		repeat (3) @(negedge clk);
		chk({act, mode}, 2'b11);
		mdl[5] = 12'h060;
		// Start-up with fail-safe active: writes and clears refused
		{sum, blk} = 2'b11;
		acc(3'h1, 1'b0, ~mdl[1][11:0]);
		acc(3'h5, 1'b0, 12'h000);
		acc(3'h1, 1'b1, 12'h000);
		chk(act, 1'b1);
		{sum, blk} = 2'b00;
		acc(3'h5, 1'b0, 12'h000);
		chk(act, 1'b0);
		// Shutdown, then cooling below both thresholds in two steps
		{warn, sd} = 2'b11;
		repeat (8) @(negedge clk);
		chk({mode, wkd, act, fso_d}, 6'h38);
		sd = 1'b0;
		repeat (8) @(negedge clk);
		chk({mode, wkd}, 2'b11);
		warn = 1'b0;
		repeat (8) @(negedge clk);
		chk({mode, wkd, twe}, 3'b001);
		mdl[4] = 12'h010;
		acc(3'h4, 1'b1, 12'h000);
		i_mst.xfer(16'h0000, 8, rx);
		repeat (8) @(negedge clk);
		chk(spif, 1'b1);
		// Mid-run resets: reset policy, then development setup
		for (int c = 0; c < 2; c++) begin
			rst_n = 1'b0;
			cfgm = 1'b1;
			swdev = c[0];
			cfgp = c[0] & 1'($urandom);
			repeat (4) @(negedge clk);
			rst_n = 1'b1;
			repeat (4) @(negedge clk);
			cfgm = 1'b0;
			chk({spif, act, mode, swd}, {3'b000, c[0]});
			clamp = 1'b1;
			@(negedge clk) clamp = 1'b0;
			chk(rpr, !c[0]);
			repeat (3) @(negedge clk);
			chk({act, mode, rpr}, {!c[0], 2'b00});
		end
		tally_and_finish();
	end
endmodule // sfc_top_bench
`default_nettype wire
